//--- afp_pkg.sv
package afp_pkg;
	localparam int NCH = 4;

	// clip/warning output source selection
	typedef enum logic [1:0] {
		SRC_CLIP  = 2'h0,
		SRC_WARN  = 2'h1,
		SRC_BOTH  = 2'h2,
		SRC_TWEET = 2'h3
	} afp_src_type;
	localparam afp_src_type SRC_RESET = SRC_WARN;

	// device register indices (byte offsets on the control link)
	localparam logic [7:0] REG_FAULT  = 8'h00; // latched fault flags, write 1 clears
	localparam logic [7:0] REG_OVERCURRENT_SHUTDOWN   = 8'h01; // per-channel overcurrent shutdown flags
	localparam logic [7:0] REG_DC     = 8'h02; // per-channel dc detect flags
	localparam logic [7:0] REG_TEMP   = 8'h04; // warning levels in bits 7..5
	localparam logic [7:0] REG_CTRL   = 8'h0a; // clip source and dc shutdown enable
	localparam logic [7:0] REG_DCTIME = 8'h0b; // dc persistence, in 1 us ticks
	localparam logic [7:0] REG_PLAY   = 8'h0c; // write 1 to restart a channel

	// fault register bit positions
	localparam int FB_OC    = 0;
	localparam int FB_DC    = 1;
	localparam int FB_OVERTEMP_SHUTDOWN  = 2;
	localparam int FB_UVP   = 3;
	localparam int FB_UVA   = 4;
	localparam int FB_UVC   = 5;
	localparam int FB_OV    = 6;
	localparam int FB_LDUMP = 7;

	// temperature register field and control fields
	localparam int TEMP_LSB  = 5;
	localparam int CTRL_DCEN = 2;

	// timing
	localparam int CLK_MHZ      = 100;
	localparam int OVERCURRENT_SHUTDOWN_MIN_US  = 200;
	localparam int OVERCURRENT_SHUTDOWN_MAX_US  = 390;
	localparam int OVERCURRENT_SHUTDOWN_CYC     = OVERCURRENT_SHUTDOWN_MIN_US * CLK_MHZ; // shut down at the earliest point
	localparam int US_CYC       = CLK_MHZ;
	localparam logic [7:0] DCTIME_RESET = 8'h0a;
endpackage

//--- afp_link_if.sv
`timescale 1ns/1ns
// register link between amplifier monitor and host controller
interface afp_link_if;
	import afp_pkg::*;
	logic       req;
	logic       we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;
	logic       rdataEn;   // device drives read data; low during power-on reset
	logic       faultOut;
	logic       clipWarnOut;

	modport dev  (input req, we, addr, wdata, output ack, rdata, rdataEn, faultOut, clipWarnOut);
	modport host (output req, we, addr, wdata, input ack, rdata, rdataEn, faultOut, clipWarnOut);
endinterface

//--- afp_persist.sv
`timescale 1ns/1ns
// counts how long a level has stood; fires once it has held for limit plus one ticks
module afp_persist #(
	parameter int W = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic         tick,
	input  wire logic         level,
	input  wire logic [W-1:0] limit,
	output      logic         fired
);
	import afp_pkg::*;
	// a counter without bits cannot hold any persistence time
	if (W < 1) begin : g_bad_w
		$error("afp_persist: W must be at least 1");
	end
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         fired;
	} afp_pst_type;
	afp_pst_type st_reg, st_next;

	// any drop of the level restarts the count
	always_comb begin
		st_next = st_reg;
		if (!level) begin
			st_next.cnt = '0;
			st_next.fired = 1'b0;
		end else if (tick && !st_reg.fired) begin
			if (st_reg.cnt >= limit) st_next.fired = 1'b1;
			else st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) st_reg <= '0;
		else st_reg <= st_next;
	end
	assign fired = st_reg.fired;
endmodule // afp_persist

//--- afp_device.sv
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// - average overcurrent trims pulse, channel keeps playing
// - peak short shuts channel in window
// - overcurrent shutdown raises fault, records channel
// - brief peak limit returns without record
// - dc offset held for programmed time triggers
// - dc shutdown optional, only that channel
// - clip output holds while any full duty
// - clip output source selectable four ways
// - after reset source is temperature warning
// - warning source asserts at 125 degrees
// - three warning levels in status bits 7..5
// - 155 degrees floats all outputs, raises fault
// - shutdown releases at 145, outputs return without host restart
// - undervoltage raises fault, flags supply
// - power-on reset floats control link
// - overvoltage raises fault, records it
// - load dump shuts down until host restart
// - faults float outputs immediately, no ramp
// - host clears faults and restarts channels
module afp_device #(
	parameter int OVERCURRENT_SHUTDOWN_CYCLES = afp_pkg::OVERCURRENT_SHUTDOWN_CYC
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	afp_link_if.dev                     link,
	input  wire logic [afp_pkg::NCH-1:0] avgOverCur,    // average current over threshold
	input  wire logic [afp_pkg::NCH-1:0] peakOverCur,   // peak detector
	input  wire logic [afp_pkg::NCH-1:0] dcPos,         // offset above positive threshold
	input  wire logic [afp_pkg::NCH-1:0] dcNeg,         // offset below negative threshold
	input  wire logic [afp_pkg::NCH-1:0] fullDuty,      // pwm at full duty cycle
	input  wire logic [afp_pkg::NCH-1:0] tweetDetect,
	input  wire logic [2:0]              tempWarnRaw,   // comparators 125/135/145 rising
	input  wire logic [2:0]              tempWarnFall,  // same, minus 10 degree hysteresis
	input  wire logic                    tempShutHi,    // at or above 155
	input  wire logic                    tempShutLo,    // still above 145
	input  wire logic                    uvPower,
	input  wire logic                    uvAnalog,
	input  wire logic                    uvPump,
	input  wire logic                    ovPower,
	input  wire logic                    loadDump,
	output      logic [afp_pkg::NCH-1:0] pulseCutOut,   // terminate current pwm pulse
	output      logic [afp_pkg::NCH-1:0] outputFloat    // channel in output_float_state
);
	import afp_pkg::*;

	// the peak timer must not run past the shutdown window; 16 bits hold the longest
	if (OVERCURRENT_SHUTDOWN_CYCLES < 1 || OVERCURRENT_SHUTDOWN_CYCLES > OVERCURRENT_SHUTDOWN_MAX_US * CLK_MHZ) begin : g_bad_overcurrent_shutdown
		$error("afp_device: OVERCURRENT_SHUTDOWN_CYCLES outside shutdown window");
	end

	typedef struct packed {
		logic [NCH-1:0]   cut;
		logic [NCH-1:0]   chOff;       // channel held off until host restart
		logic [NCH-1:0]   ocFlag;
		logic [NCH-1:0]   dcFlag;
		logic [7:0]       fault;
		logic [2:0]       warn;
		logic             overtemp_shutdown;
		logic             ldump;
		logic             dcShutEn;
		afp_src_type      src;
		logic [7:0]       dcTime;
		logic [6:0]       usCnt;
		logic             ack;
		logic [7:0]       rdata;
		logic             rdEn;
		logic             faultPin;
		logic             clipPin;
		logic [NCH-1:0]   floatOut;
	} afp_dev_type;
	afp_dev_type st_reg, st_next;

	logic [NCH-1:0] ocFire;
	logic [NCH-1:0] dcFire;
	logic           usTick;
	assign usTick = (st_reg.usCnt == 7'(US_CYC - 1));

	// per-channel persistence: peak short timing and dc offset timing
	genvar gi;
	for (gi = 0; gi < NCH; gi++) begin : g_ch
		afp_persist #(.W(16)) u_oc (
			.core_clk (core_clk),
			.rst_b    (rst_b),
			.tick     (1'b1),
			.level    (peakOverCur[gi] && !st_reg.chOff[gi]),
			.limit    (16'(OVERCURRENT_SHUTDOWN_CYCLES - 1)),
			.fired    (ocFire[gi])
		);
		afp_persist #(.W(8)) u_dc (
			.core_clk (core_clk),
			.rst_b    (rst_b),
			.tick     (usTick),
			.level    ((dcPos[gi] || dcNeg[gi]) && !st_reg.chOff[gi]),
			.limit    (st_reg.dcTime),
			.fired    (dcFire[gi])
		);
	end

	// write-one-to-clear with set winning over clear
	function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr,
		input logic [7:0] set);
		w1c = (cur & ~clr) | set;
	endfunction

	always_comb begin
		logic [7:0] setF;
		logic [7:0] clrF;
		logic [NCH-1:0] clrOc;
		logic [NCH-1:0] clrDc;
		logic [NCH-1:0] restart;
		logic [NCH-1:0] newDcOff;
		logic anyClip;
		logic warnLvl;
		logic globalOff;
		st_next = st_reg;
		setF = '0;
		anyClip = 1'b0;
		warnLvl = 1'b0;
		globalOff = 1'b0;
		clrF = '0;
		clrOc = '0;
		clrDc = '0;
		restart = '0;
		newDcOff = st_reg.dcShutEn ? dcFire : '0;
		st_next.usCnt = usTick ? '0 : st_reg.usCnt + 7'h01;
		st_next.cut = avgOverCur; // trims pulse only, never shuts down

		// warning levels with hysteresis
		for (int i = 0; i < 3; i++) begin
			if (tempWarnRaw[i]) st_next.warn[i] = 1'b1;
			else if (!tempWarnFall[i]) st_next.warn[i] = 1'b0;
		end
		if (tempShutHi) st_next.overtemp_shutdown = 1'b1;
		else if (!tempShutLo) st_next.overtemp_shutdown = 1'b0;
		if (loadDump) st_next.ldump = 1'b1;

		// register access, one cycle answer
		st_next.ack = 1'b0;
		if (link.req && !st_reg.ack) begin
			st_next.ack = 1'b1;
			if (link.we) begin
				case (link.addr)
					REG_FAULT:  clrF = link.wdata;
					REG_OVERCURRENT_SHUTDOWN:   clrOc = link.wdata[NCH-1:0];
					REG_DC:     clrDc = link.wdata[NCH-1:0];
					REG_CTRL: begin
						st_next.src = afp_src_type'(link.wdata[1:0]);
						st_next.dcShutEn = link.wdata[CTRL_DCEN];
					end
					REG_DCTIME: st_next.dcTime = link.wdata;
					REG_PLAY: begin
						restart = link.wdata[NCH-1:0];
						if (!loadDump) st_next.ldump = 1'b0;
					end
					default: ;
				endcase
			end else begin
				case (link.addr)
					REG_FAULT:  st_next.rdata = st_reg.fault;
					REG_OVERCURRENT_SHUTDOWN:   st_next.rdata = 8'(st_reg.ocFlag);
					REG_DC:     st_next.rdata = 8'(st_reg.dcFlag);
					REG_TEMP:   st_next.rdata = {st_reg.warn, 5'h00};
					REG_CTRL:   st_next.rdata = {5'h00, st_reg.dcShutEn, st_reg.src};
					REG_DCTIME: st_next.rdata = st_reg.dcTime;
					default:    st_next.rdata = 8'h00;
				endcase
			end
		end

		// latched flags: set wins over clear
		setF[FB_OC]    = |ocFire;
		setF[FB_DC]    = |dcFire;
		setF[FB_OVERTEMP_SHUTDOWN]  = tempShutHi;
		setF[FB_UVP]   = uvPower;
		setF[FB_UVA]   = uvAnalog;
		setF[FB_UVC]   = uvPump;
		setF[FB_OV]    = ovPower;
		setF[FB_LDUMP] = loadDump;
		st_next.fault  = w1c(st_reg.fault, clrF, setF);
		st_next.ocFlag = NCH'(w1c(8'(st_reg.ocFlag), 8'(clrOc), 8'(ocFire)));
		st_next.dcFlag = NCH'(w1c(8'(st_reg.dcFlag), 8'(clrDc), 8'(dcFire)));
		st_next.chOff  = (st_reg.chOff & ~restart) | ocFire | newDcOff;

		// shared clip/warning output
		anyClip = |fullDuty;
		warnLvl = st_reg.warn[0]; // 125 degree level
		case (st_reg.src)
			SRC_CLIP:  st_next.clipPin = anyClip;
			SRC_WARN:  st_next.clipPin = warnLvl;
			SRC_BOTH:  st_next.clipPin = anyClip || warnLvl;
			SRC_TWEET: st_next.clipPin = |tweetDetect;
			default:   st_next.clipPin = 1'b0;
		endcase

		// outputs float at once on any fault except dc detect with dc shutdown off, with no gain ramp
		globalOff = st_reg.overtemp_shutdown || st_reg.ldump || uvPower || uvAnalog || uvPump || ovPower;
		st_next.floatOut = st_next.chOff | {NCH{globalOff}};
		st_next.faultPin = |ocFire || |newDcOff || st_reg.overtemp_shutdown || st_reg.ldump
			|| uvPower || uvAnalog || uvPump || ovPower || (|st_reg.chOff);
		st_next.rdEn = 1'b1; // link released once out of reset
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
			st_reg.src <= SRC_RESET;
			st_reg.dcTime <= DCTIME_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.ack = st_reg.ack;
	assign link.rdata = st_reg.rdata;
	assign link.rdataEn = st_reg.rdEn; // low in reset
	assign link.faultOut = st_reg.faultPin;
	assign link.clipWarnOut = st_reg.clipPin;
	assign pulseCutOut = st_reg.cut;
	assign outputFloat = st_reg.floatOut;
endmodule // afp_device

//--- afp_host.sv
`timescale 1ns/1ns
// host end: wishbone classic slave for software, drives the device link
module afp_host (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	afp_link_if.host         link,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output      logic [31:0] wb_dat_o,
	output      logic        wb_ack_o
);
	import afp_pkg::*;
	// word index 0..0xff maps straight to device register; word index 0x100 alone selects pin status
	localparam logic [31:0] HOST_STATUS = 32'h0000_0400;

	typedef enum {H_IDLE, H_WAIT, H_DONE} afp_hst_type;
	typedef struct packed {
		afp_hst_type st;
		logic        req;
		logic        we;
		logic [7:0]  addr;
		logic [7:0]  wdata;
		logic [31:0] dat;
		logic        ack;
	} afp_host_type;
	afp_host_type s_reg, s_next;

	// host forwards mapped reads and low-lane writes; clears and restarts are plain writes
	always_comb begin
		s_next = s_reg;
		s_next.ack = 1'b0;
		case (s_reg.st)
			H_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					if (wb_adr_i == HOST_STATUS) begin
						s_next.dat = {30'h0, link.clipWarnOut, link.faultOut};
						s_next.ack = 1'b1;
						s_next.st = H_DONE;
					end else if (wb_adr_i[31:10] != 22'h0 || wb_adr_i[1:0] != 2'h0) begin
						s_next.dat = 32'h0; // unmapped: answer zero
						s_next.ack = 1'b1;
						s_next.st = H_DONE;
					end else if (!wb_we_i || wb_sel_i[0]) begin
						s_next.req = 1'b1;
						s_next.we = wb_we_i;
						s_next.addr = wb_adr_i[9:2];
						s_next.wdata = wb_dat_i[7:0];
						s_next.st = H_WAIT;
					end else begin
						s_next.ack = 1'b1; // write with low lane disabled
						s_next.st = H_DONE;
					end
				end
			end
			H_WAIT: begin
				if (link.ack) begin
					s_next.req = 1'b0;
					s_next.dat = {24'h0, link.rdataEn ? link.rdata : 8'h00};
					s_next.ack = 1'b1;
					s_next.st = H_DONE;
				end
			end
			H_DONE: s_next.st = H_IDLE; // holds for the one cycle that ack is high, request ignored
			default: s_next.st = H_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) s_reg <= '{st: H_IDLE, default: '0};
		else s_reg <= s_next;
	end

	assign link.req = s_reg.req;
	assign link.we = s_reg.we;
	assign link.addr = s_reg.addr;
	assign link.wdata = s_reg.wdata;
	assign wb_dat_o = s_reg.dat;
	assign wb_ack_o = s_reg.ack;
endmodule // afp_host

//--- afp_link_sva.sv
`timescale 1ns/1ns
// watches the register link that joins host end and device end
module afp_link_sva (
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       req,
	input wire logic       we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       ack,
	input wire logic [7:0] rdata,
	input wire logic       rdataEn,
	input wire logic       faultOut,
	input wire logic       clipWarnOut
);
	import afp_pkg::*;
	typedef struct packed {
		logic [2:0] ctrl;
		logic [7:0] dcTime;
	} afp_shadow_type;
	afp_shadow_type shadow_reg;
	afp_shadow_type shadow_next;

	// ----------------------------------------
	// shadow of host settings, so readback can be judged
	// ----------------------------------------
	always_comb begin
		shadow_next = shadow_reg;
		if (req && !ack && we && addr == REG_CTRL)
			shadow_next.ctrl = wdata[2:0];
		if (req && !ack && we && addr == REG_DCTIME)
			shadow_next.dcTime = wdata;
	end

	// reset values match the device's own reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			shadow_reg <= '{ctrl: {1'b0, SRC_RESET}, dcTime: DCTIME_RESET};
		else
			shadow_reg <= shadow_next;
	end

	// ----------------------------------------
	// link properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence taken_s;
		req && !ack;
	endsequence
	sequence read_answer_s;
		ack && !we;
	endsequence

	property req_hold_p;
		taken_s |=> req && $stable(addr) && $stable(wdata);
	endproperty
	property ctrl_back_p;
		read_answer_s ##0 addr == REG_CTRL |-> rdata[2:0] == shadow_reg.ctrl;
	endproperty
	property dc_time_back_p;
		read_answer_s ##0 addr == REG_DCTIME |-> rdata == shadow_reg.dcTime;
	endproperty

	ack_pulse_a: assert property (ack |=> !ack)
		else $error("link ack stood longer than one cycle");
	ack_cause_a: assert property (ack |-> $past(req))
		else $error("link ack without a request");
	answer_time_a: assert property (taken_s |=> ack)
		else $error("link request not answered next cycle");
	req_hold_a: assert property (req_hold_p)
		else $error("link request changed before its answer");
	req_release_a: assert property (ack |=> !req)
		else $error("link request held after answer");
	link_drive_a: assert property ($past(rst_b) |-> rdataEn)
		else $error("read data not driven out of reset");
	ctrl_back_a: assert property (ctrl_back_p)
		else $error("control readback differs");
	dc_time_back_a: assert property (dc_time_back_p)
		else $error("dc time readback differs");
	cover property ($rose(faultOut));
	cover property ($rose(clipWarnOut));
endmodule // afp_link_sva

//--- amp_fault_protection_monitor_bench.sv
`timescale 1ns/1ns
module amp_fault_protection_monitor_bench;
	import afp_pkg::*;
	localparam int OVERCURRENT_SHUTDOWN = 8; // short count keeps the run brief
	logic core_clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, shutHi = 0, shutLo = 0, ack;
	logic [3:0] avg = 0, peak = 0, dcP = 0, dcN = 0, full = 0, tweet = 0, sel = 0, cut, flt;
	logic [4:0] sup = 0; // load dump, over, pump, analog, power
	logic [2:0] warnRaw = 0, warnFall = 0;
	logic [31:0] adr = 0, wdat = 0, rdat;
	int fail_count = 0, check_count = 0;
	afp_link_if link ();
	afp_device #(.OVERCURRENT_SHUTDOWN_CYCLES(OVERCURRENT_SHUTDOWN)) afp_device_i (.core_clk(core_clk), .rst_b(rst_b),
		.link(link), .avgOverCur(avg), .peakOverCur(peak), .dcPos(dcP), .dcNeg(dcN),
		.fullDuty(full), .tweetDetect(tweet), .tempWarnRaw(warnRaw), .tempWarnFall(warnFall),
		.tempShutHi(shutHi), .tempShutLo(shutLo), .uvPower(sup[0]), .uvAnalog(sup[1]),
		.uvPump(sup[2]), .ovPower(sup[3]), .loadDump(sup[4]), .pulseCutOut(cut),
		.outputFloat(flt));
	afp_host afp_host_i (.core_clk(core_clk), .rst_b(rst_b), .link(link), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	afp_link_sva afp_link_sva_i (.core_clk(core_clk), .rst_b(rst_b), .req(link.req),
		.we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
		.rdata(link.rdata), .rdataEn(link.rdataEn), .faultOut(link.faultOut),
		.clipWarnOut(link.clipWarnOut));

	// ----------------------------------------
	// clock, watchdog and access tasks
	// ----------------------------------------
	initial forever #5 core_clk = ~core_clk;
	// whole run is a few thousand cycles; this is far beyond it
	initial begin
		#500000;
		fail_count++;
		report_and_stop();
	end
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, s, e);
		end
	endtask
	task automatic cf(input logic [3:0] e);
		chk({4'h0, flt}, {4'h0, e});
	endtask
	task automatic cw(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// classic cycle: request holds until ack is sampled high; only the watchdog ends a hang
	task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge core_clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		wdat <= {24'h0, d};
		do
			@(posedge core_clk);
		while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic wr(input logic [7:0] r, d);
		logic [7:0] q;
		wb(1'b1, {22'h0, r, 2'h0}, d, q);
	endtask
	task automatic rd(input logic [7:0] r, m, e);
		logic [7:0] q;
		wb(1'b0, {22'h0, r, 2'h0}, 8'h0, q);
		chk(q & m, e);
	endtask
	// status word: bit0 fault output, bit1 clip/warning output
	task automatic rs(input logic [7:0] m, e);
		logic [7:0] q;
		wb(1'b0, 32'h400, 8'h0, q);
		chk(q & m, e);
	endtask
	// flags are cleared only once their cause has gone
	task automatic clr();
		wr(REG_FAULT, 8'hff);
		wr(REG_OVERCURRENT_SHUTDOWN, 8'hff);
		wr(REG_DC, 8'hff);
		wr(REG_PLAY, 8'h0f);
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		logic ex;
		cw(4);
		rst_b <= 1;
		rd(REG_CTRL, 8'h07, 8'h01);
		rd(REG_DCTIME, 8'hff, DCTIME_RESET);
		rd(8'h0e, 8'hff, 8'h00); // unmapped place reads zero
		warnRaw <= 3'h1;
		warnFall <= 3'h1;
		cw(2); // warning level passes two flops before it reaches the pin
		rs(8'h02, 8'h02);
		$display("test reset done");
		avg <= 4'h5;
		cw(3);
		chk({4'h0, cut}, 8'h05);
		cf(4'h0);
		rs(8'h01, 8'h00);
		avg <= 4'h0;
		peak <= 4'h4;
		cw(6);
		cf(4'h0);
		cw(8);
		cf(4'h4);
		rs(8'h01, 8'h01);
		peak <= 4'h0;
		rd(REG_OVERCURRENT_SHUTDOWN, 8'hff, 8'h04);
		rd(REG_FAULT, 8'h01, 8'h01);
		clr();
		cf(4'h0);
		rd(REG_OVERCURRENT_SHUTDOWN, 8'hff, 8'h00);
		peak <= 4'h2;
		cw(3);
		peak <= 4'h0;
		cw(2 * OVERCURRENT_SHUTDOWN);
		cf(4'h0);
		rd(REG_OVERCURRENT_SHUTDOWN, 8'hff, 8'h00);
		$display("test current done");
		wr(REG_DCTIME, 8'h03);
		dcP <= 4'h2;
		cw(250);
		dcP <= 4'h0;
		rd(REG_DC, 8'hff, 8'h00);
		dcP <= 4'h1;
		cw(600);
		cf(4'h0);
		rd(REG_DC, 8'hff, 8'h01);
		dcP <= 4'h0;
		clr();
		wr(REG_CTRL, 8'h05);
		dcN <= 4'h8;
		cw(600);
		cf(4'h8);
		rs(8'h01, 8'h01);
		dcN <= 4'h0;
		clr();
		$display("test dc done");
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 3; k++) begin
				wr(REG_CTRL, 8'(s));
				full <= (k == 0) ? 4'h2 : 4'h0;
				warnRaw <= (k == 1) ? 3'h1 : 3'h0;
				warnFall <= (k == 1) ? 3'h1 : 3'h0;
				tweet <= (k == 2) ? 4'h8 : 4'h0;
				ex = (k == 0 && (s == 0 || s == 2)) || (k == 1 && (s == 1 || s == 2))
					|| (k == 2 && s == 3);
				cw(2); // let the warning level settle onto the pin
				rs(8'h02, {6'h0, ex, 1'b0});
			end
		end
		tweet <= 4'h0;
		warnRaw <= 3'h7;
		warnFall <= 3'h7;
		rd(REG_TEMP, 8'he0, 8'he0);
		warnRaw <= 3'h0;
		warnFall <= 3'h1;
		rd(REG_TEMP, 8'he0, 8'h20);
		warnFall <= 3'h0;
		rd(REG_TEMP, 8'he0, 8'h00);
		shutHi <= 1;
		shutLo <= 1;
		cw(3);
		cf(4'hf);
		rs(8'h01, 8'h01);
		rd(REG_FAULT, 8'h04, 8'h04);
		shutHi <= 0;
		wr(REG_PLAY, 8'h0f);
		cf(4'hf);
		shutLo <= 0;
		clr();
		cf(4'h0);
		$display("test temperature done");
		for (int i = 0; i < 4; i++) begin
			sup <= 5'h1 << i;
			cw(3);
			cf(4'hf);
			rs(8'h01, 8'h01);
			rd(REG_FAULT, 8'h08 << i, 8'h08 << i);
			sup <= 5'h0;
			clr();
		end
		sup <= 5'h10;
		cw(3);
		cf(4'hf);
		sup <= 5'h0;
		cw(3);
		cf(4'hf);
		rd(REG_FAULT, 8'h80, 8'h80);
		clr();
		cf(4'h0);
		$display("test supply done");
		// second reset mid-run: link floats, settings fall back, host must set them again
		rst_b <= 0;
		cw(2);
		chk({7'h0, link.rdataEn}, 8'h00);
		rst_b <= 1;
		rd(REG_CTRL, 8'h07, 8'h01);
		rd(REG_DCTIME, 8'hff, DCTIME_RESET);
		wr(REG_DCTIME, 8'h03);
		rd(REG_DCTIME, 8'hff, 8'h03);
		$display("test reset again done");
		report_and_stop();
	end
endmodule // amp_fault_protection_monitor_bench
